// File: rssalu_core.sv
/*
  Datapath slice executing rotate-right through carry, enter-standby, the
  three subtracts and nibble exchange, with accumulator and status bits.
  Assumes the decoder presents one registered instruction per cycle and that
  data memory supplies the addressed register in reg_rd_data the same cycle.
*/
// Overview of operation
// RULE1: Rotate right through carry; old bit 0 to carry, old carry to bit 7.
// RULE2: Target select 0 writes accumulator, 1 writes addressed register.
// RULE3: Enter standby clears watchdog counter and its prescaler.
// RULE4: Enter standby clears power-down bit and sets watchdog-expired bit.
// RULE5: Subtract accumulator from register, result to selected target.
// RULE6: Literal minus accumulator, result always to accumulator.
// RULE7: Carry is 0 when accumulator exceeds operand; digit carry is 0 when its low nibble exceeds the operand's.
// RULE8: Register minus accumulator minus inverted carry; updates C, DC, Z.
// RULE9: Nibble exchange swaps register nibbles into selected target.
// RULE10: Zero flag set when subtraction result is zero, else cleared.
// RULE11: Rotate, swap and standby leave zero and digit carry unchanged.
`include "rssalu_consts.svh"
`timescale 1ns/100ps

module rssalu_core (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Instruction from decoder, register operand from data memory
  input  wire rssalu_pkg::rssalu_instr_t  instr,
  input  wire logic [`RSSALU_DATA_W-1:0]  reg_rd_data,
  // Write-back to data memory
  output rssalu_pkg::rssalu_wb_t          wb,
  // Architectural state
  output logic [`RSSALU_DATA_W-1:0]       acc,
  output rssalu_pkg::rssalu_status_t      status,
  // Watchdog clear towards the watchdog block
  output logic                            wdt_clear,
  output logic [`RSSALU_DATA_W-1:0]       watchdog_counter_val,
  output logic [`RSSALU_DATA_W-1:0]       wdt_prescaler_val
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [`RSSALU_DATA_W-1:0]  acc_q;
  logic [`RSSALU_DATA_W-1:0]  acc_d;
  rssalu_pkg::rssalu_status_t st_q;
  rssalu_pkg::rssalu_status_t st_d;
  rssalu_pkg::rssalu_wb_t     wb_q;
  rssalu_pkg::rssalu_wb_t     wb_d;
  logic                       wdtc_q;
  logic                       wdtc_d;
  logic [`RSSALU_DATA_W-1:0]  wdt_q;
  logic [`RSSALU_DATA_W-1:0]  wdt_d;
  logic [`RSSALU_DATA_W-1:0]  pre_q;
  logic [`RSSALU_DATA_W-1:0]  pre_d;
  logic [`RSSALU_DATA_W-1:0]  result;
  logic                       has_result;
  logic                       to_acc;

  // ------------------------------------------------------------------
  // Subtractor
  // ------------------------------------------------------------------
  logic [`RSSALU_DATA_W-1:0]  sub_a;
  logic                       sub_bin;
  logic [`RSSALU_DATA_W-1:0]  sub_diff;
  logic                       sub_c;
  logic                       sub_dc;
  logic                       sub_zero;

  // One shared subtractor serves all three subtract forms; only its
  // first operand and its borrow in change between them.
  rssalu_sub #(
    .W (`RSSALU_DATA_W)
  ) u_sub (
    .a                (sub_a),
    .b                (acc_q),
    .borrow_in        (sub_bin),
    .diff             (sub_diff),
    .carry_not_borrow (sub_c),
    .half_not_borrow  (sub_dc)
  );

  // Zero detect on the 8-bit difference, shared by the three forms.
  assign sub_zero = (sub_diff == '0); // RULE10

  // ------------------------------------------------------------------
  // Operand select
  // ------------------------------------------------------------------
  // The operands depend only on the instruction, reg_rd_data and the registered carry,
  // never on the subtractor's outputs, so they are picked in a process of
  // their own; this keeps the next-state process free of feedback.
  always_comb begin
    sub_a   = reg_rd_data;
    sub_bin = 1'b0;
    if (instr.valid) begin
      case (instr.op)
        rssalu_pkg::RSSALU_OP_SUB_W_FROM_LITERAL: begin
          sub_a = instr.literal_val; // RULE6
        end
        rssalu_pkg::RSSALU_OP_SUB_W_FROM_REG_BORROW: begin
          sub_bin = ~st_q.borrow_not_bit; // RULE8
        end
        default: begin
          sub_bin = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    acc_d      = acc_q;
    st_d       = st_q;
    wdtc_d     = 1'b0;
    wdt_d      = wdt_q;
    pre_d      = pre_q;
    result     = reg_rd_data;
    has_result = 1'b0;
    to_acc     = (instr.result_target_sel == `RSSALU_DEST_ACC); // RULE2
    wb_d       = '0;
    if (instr.valid) begin
      case (instr.op)
        rssalu_pkg::RSSALU_OP_ROTATE_RIGHT_CARRY: begin
          result            = {st_q.borrow_not_bit,
                               reg_rd_data[`RSSALU_DATA_W-1:1]}; // RULE1
          st_d.borrow_not_bit = reg_rd_data[0]; // RULE1
          // Only the carry moves; digit carry and zero keep their values.
          has_result        = 1'b1; // RULE11
        end
        rssalu_pkg::RSSALU_OP_ENTER_STANDBY: begin
          // The counters here are held copies only; the wdt_clear pulse is
          // what actually clears the watchdog outside this slice.
          wdt_d               = `RSSALU_WDT_CLEAR; // RULE3
          pre_d               = `RSSALU_PRE_CLEAR; // RULE3
          wdtc_d              = 1'b1; // RULE3
          st_d.power_down_bit = 1'b0; // RULE4
          st_d.watchdog_expired_bit = 1'b1; // RULE4
        end
        rssalu_pkg::RSSALU_OP_SUB_W_FROM_REG: begin
          result                   = sub_diff; // RULE5
          has_result               = 1'b1;
          st_d.borrow_not_bit      = sub_c; // RULE7
          st_d.half_borrow_not_bit = sub_dc; // RULE7
          st_d.result_null_flag    = sub_zero; // RULE10
        end
        rssalu_pkg::RSSALU_OP_SUB_W_FROM_LITERAL: begin
          // The literal form ignores the target select.
          result                   = sub_diff; // RULE6
          has_result               = 1'b1;
          to_acc                   = 1'b1; // RULE6
          st_d.borrow_not_bit      = sub_c; // RULE7
          st_d.half_borrow_not_bit = sub_dc; // RULE7
          st_d.result_null_flag    = sub_zero; // RULE10
        end
        rssalu_pkg::RSSALU_OP_SUB_W_FROM_REG_BORROW: begin
          // The carry out feeds the next borrow in, so a run of these
          // subtracts walks up operands wider than one byte.
          result                   = sub_diff; // RULE8
          has_result               = 1'b1;
          st_d.borrow_not_bit      = sub_c; // RULE8
          st_d.half_borrow_not_bit = sub_dc; // RULE8
          st_d.result_null_flag    = sub_zero; // RULE8
        end
        rssalu_pkg::RSSALU_OP_NIBBLE_EXCHANGE: begin
          result = {reg_rd_data[`RSSALU_NIB_LO_MSB:0],
                    reg_rd_data[`RSSALU_DATA_W-1:`RSSALU_NIB_HI_LSB]}; // RULE9
          has_result = 1'b1; // RULE11
        end
        default: begin
          has_result = 1'b0;
        end
      endcase
      if (has_result) begin
        if (to_acc) begin
          acc_d = result; // RULE2
        end else begin
          // The write-back is registered, so data memory must forward it
          // to a read of the same address in the following cycle.
          wb_d.en   = 1'b1; // RULE2
          wb_d.addr = instr.addr;
          wb_d.data = result;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Reset is synchronous; power-down and time-out leave reset high, which
  // is their inactive level.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_q  <= `RSSALU_ACC_RST;
      st_q   <= '{borrow_not_bit:       `RSSALU_FLAG_RST,
                  half_borrow_not_bit:  `RSSALU_FLAG_RST,
                  result_null_flag:     `RSSALU_FLAG_RST,
                  power_down_bit:       `RSSALU_PD_RST,
                  watchdog_expired_bit: `RSSALU_TO_RST};
      wb_q   <= '0;
      wdtc_q <= 1'b0;
      wdt_q  <= `RSSALU_WDT_CLEAR;
      pre_q  <= `RSSALU_PRE_CLEAR;
    end else begin
      acc_q  <= acc_d;
      st_q   <= st_d;
      wb_q   <= wb_d;
      wdtc_q <= wdtc_d;
      wdt_q  <= wdt_d;
      pre_q  <= pre_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign acc                  = acc_q;
  assign status               = st_q;
  assign wb                   = wb_q;
  assign wdt_clear            = wdtc_q;
  assign watchdog_counter_val = wdt_q;
  assign wdt_prescaler_val    = pre_q;

endmodule // rssalu_core

// File: rssalu_consts.svh
/*
  Constants for the rotate/subtract/swap datapath slice: operand widths,
  nibble positions, reset values of the status bits and the address range.
  Assumes it is included by its bare name from the package and the modules.
*/
`ifndef RSSALU_CONSTS_SVH
`define RSSALU_CONSTS_SVH

`define RSSALU_DATA_W      8
`define RSSALU_ADDR_W      7
`define RSSALU_ADDR_MAX    7'h7f
`define RSSALU_LIT_MAX     8'hff
`define RSSALU_NIB_LO_MSB  3
`define RSSALU_NIB_HI_LSB  4
`define RSSALU_DEST_ACC    1'b0
`define RSSALU_DEST_REG    1'b1
`define RSSALU_WDT_CLEAR   8'h00
`define RSSALU_PRE_CLEAR   8'h00
`define RSSALU_ACC_RST     8'h00
`define RSSALU_FLAG_RST    1'b0
`define RSSALU_PD_RST      1'b1
`define RSSALU_TO_RST      1'b1

`endif

// File: rssalu_pkg.sv
/*
  Types for the rotate/subtract/swap datapath slice.
  Assumes rssalu_consts.svh is on the include path.
*/
`include "rssalu_consts.svh"

package rssalu_pkg;

  typedef enum logic [2:0] {
    RSSALU_OP_NONE,
    RSSALU_OP_ROTATE_RIGHT_CARRY,
    RSSALU_OP_ENTER_STANDBY,
    RSSALU_OP_SUB_W_FROM_REG,
    RSSALU_OP_SUB_W_FROM_LITERAL,
    RSSALU_OP_SUB_W_FROM_REG_BORROW,
    RSSALU_OP_NIBBLE_EXCHANGE
  } rssalu_op_t;

  // One decoded instruction as handed over by the decoder.
  typedef struct packed {
    logic                        valid;
    rssalu_op_t                  op;
    logic [`RSSALU_ADDR_W-1:0]   addr;
    logic                        result_target_sel;
    logic [`RSSALU_DATA_W-1:0]   literal_val;
  } rssalu_instr_t;

  // Status bits kept by the slice.
  typedef struct packed {
    logic borrow_not_bit;
    logic half_borrow_not_bit;
    logic result_null_flag;
    logic power_down_bit;
    logic watchdog_expired_bit;
  } rssalu_status_t;

  // Write-back request towards data memory.
  typedef struct packed {
    logic                        en;
    logic [`RSSALU_ADDR_W-1:0]   addr;
    logic [`RSSALU_DATA_W-1:0]   data;
  } rssalu_wb_t;

endpackage

// File: rssalu_sub.sv
/*
  Combinational subtractor: a - b - borrow_in with borrow-not outputs.
  Assumes operands are stable within the cycle from registered sources.
*/
`include "rssalu_consts.svh"
`timescale 1ns/100ps

module rssalu_sub #(
  parameter int W = `RSSALU_DATA_W
) (
  // Operands
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         borrow_in,
  // Results
  output logic      [W-1:0] diff,
  output logic              carry_not_borrow,
  output logic              half_not_borrow
);

  logic [W:0] full;
  logic [4:0] low;

  always_comb begin
    full = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, borrow_in};
    low  = {1'b0, a[`RSSALU_NIB_LO_MSB:0]} - {1'b0, b[`RSSALU_NIB_LO_MSB:0]}
           - {4'h0, borrow_in};
    diff             = full[W-1:0];
    carry_not_borrow = ~full[W];
    half_not_borrow  = ~low[4];
  end

endmodule // rssalu_sub

// File: rssalu_chk.sv
/* Port checker for rssalu_core, one clock domain.
   Assumes the bind below and the package compiled first. */
`timescale 1ns/100ps
module rssalu_chk (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       resetn,
  // Observed ports
  input wire rssalu_pkg::rssalu_instr_t  instr,
  input wire logic [7:0]                 reg_rd_data,
  input wire rssalu_pkg::rssalu_wb_t     wb,
  input wire logic [7:0]                 acc,
  input wire rssalu_pkg::rssalu_status_t status,
  input wire logic                       wdt_clear,
  input wire logic [7:0]                 watchdog_counter_val,
  input wire logic [7:0]                 wdt_prescaler_val
);
  // ----
  // Helpers; opcodes follow the declaration order of the enum.
  // ----
  logic       v, c, sub, regop;
  logic [2:0] op;
  logic [7:0] res;
  // Operands of the instruction taken at the previous edge.
  logic [7:0] r_q, w_q, k_q;
  logic [6:0] a_q;
  logic       c_q, s_q;
  assign v = instr.valid;
  assign op = instr.op;
  assign c = status.borrow_not_bit;
  assign sub = v && op inside {3'h3, 3'h4, 3'h5};
  assign regop = v && op inside {3'h1, 3'h3, 3'h5, 3'h6};
  assign res = wb.en ? wb.data : acc;
  always_ff @(posedge clk) begin
    r_q <= reg_rd_data;
    w_q <= acc;
    k_q <= instr.literal_val;
    a_q <= instr.addr;
    c_q <= c;
    s_q <= instr.result_target_sel;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence stby;
    v && op == 3'h2;
  endsequence
  sequence rot_s;
    v && op == 3'h1;
  endsequence
  sequence swap_s;
    v && op == 3'h6;
  endsequence
  property rot_p;
    rot_s |=> c == r_q[0] && res == {c_q, r_q[7:1]};
  endproperty
  property swap_p;
    swap_s |=> res == {r_q[3:0], r_q[7:4]}
      && $stable(status.result_null_flag)
      && $stable(status.half_borrow_not_bit);
  endproperty
  property dest_p;
    regop |=> wb.en == s_q && (!s_q || wb.addr == a_q);
  endproperty
  property lit_p;
    v && op == 3'h4 |=> !wb.en && acc == k_q - w_q;
  endproperty
  property subf_p;
    v && op == 3'h3 |=> res == r_q - w_q && c == (w_q <= r_q)
      && status.half_borrow_not_bit == (w_q[3:0] <= r_q[3:0]);
  endproperty
  property brw_p;
    v && op == 3'h5 |=> res == r_q - w_q - {7'h00, !c_q}
      && c == ({1'b0, w_q} + {8'h00, !c_q} <= {1'b0, r_q})
      && status.half_borrow_not_bit
         == ({1'b0, w_q[3:0]} + {4'h0, !c_q} <= {1'b0, r_q[3:0]});
  endproperty
  property keep_p;
    v && op inside {3'h1, 3'h2} |=> $stable(status.result_null_flag)
      && $stable(status.half_borrow_not_bit);
  endproperty
  wdt_cleared_a:
    assert property (stby |=> wdt_clear && watchdog_counter_val == 8'h00
      && wdt_prescaler_val == 8'h00) else $error("watchdog not cleared");
  standby_bits_a:
    assert property (stby |=> !status.power_down_bit
      && status.watchdog_expired_bit) else $error("standby bits wrong");
  rotate_carry_a:
    assert property (rot_p) else $error("rotate result wrong");
  swap_nibbles_a:
    assert property (swap_p) else $error("swap result wrong");
  target_select_a:
    assert property (dest_p) else $error("destination wrong");
  literal_sub_a:
    assert property (lit_p) else $error("literal subtract wrong");
  sub_flags_a:
    assert property (subf_p) else $error("subtract or flags wrong");
  borrow_sub_a:
    assert property (brw_p) else $error("borrow subtract wrong");
  zero_flag_a:
    assert property (sub |=> status.result_null_flag == (res == 8'h00))
      else $error("zero flag wrong");
  keep_flags_a:
    assert property (keep_p) else $error("zero or digit carry changed");
endmodule // rssalu_chk
bind rssalu_core rssalu_chk u_chk (.clk, .resetn, .instr, .reg_rd_data,
  .wb, .acc, .status, .wdt_clear, .watchdog_counter_val, .wdt_prescaler_val);

// File: rssalu_mem.sv
/* Data memory model on the far side of the slice.
   Assumes the same fill pattern as the bench's own copy. */
`timescale 1ns/100ps
module rssalu_mem (
  // Clock
  input wire logic                   clk,
  // Read address and write-back
  input wire logic [6:0]             addr,
  input wire rssalu_pkg::rssalu_wb_t wb,
  // Read data
  output logic [7:0]                 rd_data
);
  logic [7:0] mem_q [128];
  initial for (int i = 0; i < 128; i++) mem_q[i] = 8'(i * 29 + 5);
  always @(posedge clk) if (wb.en) mem_q[wb.addr] <= wb.data;
  // Write-back lands a cycle late, so a pending value is forwarded.
  assign rd_data = (wb.en && wb.addr == addr) ? wb.data : mem_q[addr];
endmodule // rssalu_mem

// File: rssalu_tb_top.sv
/* Self-checking bench for rssalu_core with a data memory model.
   Assumes package, core, checker and memory model compiled first. */
`timescale 1ns/100ps
module rssalu_tb_top;
  logic clk, resetn, wdt_clear;
  logic [7:0] rd, acc, wdc, pre, ea;
  logic [4:0] es;
  logic [7:0] m [128];
  logic [31:0] rv;
  integer seed, bad_count, total_checks, cycles;
  rssalu_pkg::rssalu_instr_t instr;
  rssalu_pkg::rssalu_wb_t wb;
  rssalu_pkg::rssalu_status_t status;
  rssalu_core u_dut (.clk, .resetn, .instr, .reg_rd_data(rd), .wb, .acc,
    .status, .wdt_clear, .watchdog_counter_val(wdc), .wdt_prescaler_val(pre));
  rssalu_mem u_mem (.clk, .addr(instr.addr), .wb, .rd_data(rd));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset();
    resetn = 0;
    instr = '0;
    repeat (2) @(posedge clk);
    #1 resetn = 1;
    ea = 8'h00;
    es = 5'h03;
    check("status", {acc, status}, {ea, es});
  endtask
  // Reference subtract: {borrow-not, half-borrow-not, zero, difference}.
  function automatic logic [10:0] sub_ref(logic [7:0] x, logic [7:0] w,
                                          logic bi);
    logic [8:0] d;
    logic [4:0] h;
    d = {1'b0, x} - {1'b0, w} - {8'h00, bi};
    h = {1'b0, x[3:0]} - {1'b0, w[3:0]} - {4'h0, bi};
    return {!d[8], !h[4], d[7:0] == 8'h00, d[7:0]};
  endfunction
  // Drives one instruction, advances the reference state, checks outputs.
  task automatic step(logic [2:0] op, logic [6:0] a, logic s, logic [7:0] k,
                      logic v);
    logic [7:0] r, res;
    logic bi, wr;
    r = m[a]; bi = 0; wr = 0; res = ea;
    instr = '{v, rssalu_pkg::rssalu_op_t'(op), a, s, k};
    if (v) case (op)
      3'h1: begin res = {es[4], r[7:1]}; es[4] = r[0]; wr = s; end
      3'h2: es[1:0] = 2'h1;
      3'h6: begin res = {r[3:0], r[7:4]}; wr = s; end
      3'h3, 3'h4, 3'h5: begin
        if (op == 3'h4) r = k;
        if (op == 3'h5) bi = !es[4];
        {es[4:2], res} = sub_ref(r, ea, bi);
        wr = s && op != 3'h4;
      end
      default: ;
    endcase
    if (wr) m[a] = res; else ea = res;
    @(posedge clk);
    #1 check("acc", acc, ea);
    check("status", status, es);
    check("wb", wb, wr ? {1'b1, a, res} : 16'h0);
    check("wdt_clear", wdt_clear, v && op == 3'h2);
    check("wdt", {wdc, pre}, 16'h0);
  endtask
  initial begin
    seed = 64; bad_count = 0; total_checks = 0; cycles = 0;
    resetn = 0; instr = '0;
    for (int i = 0; i < 128; i++) m[i] = 8'(i * 29 + 5);
    do_reset();
    step(3'h4, 7'h7f, 1, 8'h3c, 1);
    step(3'h4, 7'h00, 0, 8'h2d, 1);
    step(3'h5, 7'h7f, 1, 8'h00, 1);
    step(3'h6, 7'h7f, 1, 8'h00, 1);
    step(3'h4, 7'h00, 0, 8'hf1, 1);
    step(3'h2, 7'h00, 0, 8'h00, 1);
    step(3'h2, 7'h00, 0, 8'h00, 1);
    step(3'h1, 7'h7f, 0, 8'h00, 0);
    repeat (400) begin
      rv = $random(seed);
      step(3'($unsigned(rv) % 7), rv[14:8], rv[15], rv[23:16], rv[7:4] != 0);
    end
    do_reset();
    step(3'h3, 7'h00, 1, 8'h00, 1);
    tally_and_finish();
  end
endmodule // rssalu_tb_top
